// [core_branch_call_clear_ops.sv]
/*
  executes branch-by-acc, absolute call, call-via-acc, bit set, invert,
  decrement, clear-file and clear-acc; owns pc, acc, zero flag, file regs
  and the return stack top.
  ignores op_valid while op_ready is low and assumes the fetch side
  holds operands stable for the cycle in which the op is taken.
*/
`timescale 1ns/1ps
module core_branch_call_clear_ops #(
  parameter int FILE_DEPTH = 128
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [10:0] op_literal,
  input wire logic [6:0] op_file_addr,
  input wire logic [2:0] op_bit,
  input wire logic op_dest,
  input wire logic [6:0] upper_pc_latch,
  output logic op_ready,
  output logic [14:0] pc,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic [14:0] stack_top_entry,
  output logic stack_push
);
  typedef enum logic {ST_IDLE, ST_SECOND} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [14:0] pc;
    logic [7:0] acc;
    logic zero;
    logic [14:0] ret_addr;
    logic push;
  } state_t;

  // depths that the 7-bit file address cannot serve are refused at elaboration
  if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_depth_check
    $error("FILE_DEPTH must be 1..128");
  end

  // file array held outside the struct: 128 bytes is too wide to pack sensibly
  logic [7:0] file_mem [FILE_DEPTH];
  logic file_we;
  logic [7:0] file_wdata;
  state_t state_reg, state_next;

  // zero test shared by the invert and decrement ops; the clear ops set zero directly
  function automatic logic is_zero(input logic [7:0] v);
    return (v == exec_pkg::FILE_RESET);
  endfunction

  // pc+1 is the return address and the branch base alike
  function automatic logic [14:0] pc_inc(input logic [14:0] p);
    return p + 15'h0001;
  endfunction

  logic [7:0] file_rd;
  assign file_rd = file_mem[op_file_addr];

  // decode and execute; long ops park one dead cycle in ST_SECOND
  always_comb begin
    logic [7:0] res;
    res = 8'h00;
    state_next = state_reg;
    state_next.push = 1'b0;
    file_we = 1'b0;
    file_wdata = 8'h00;
    case (state_reg.phase)
      ST_SECOND: begin
        state_next.phase = ST_IDLE; // second cycle of a two-cycle op
      end
      ST_IDLE: begin
        if (op_valid) begin
          state_next.pc = pc_inc(state_reg.pc);
          case (exec_pkg::op_t'(op_code))
            exec_pkg::OP_BRANCH_REL_ACC: begin
              state_next.pc = pc_inc(state_reg.pc) + {7'h00, state_reg.acc};
              state_next.phase = ST_SECOND;
            end
            exec_pkg::OP_CALL_ABS: begin
              state_next.ret_addr = pc_inc(state_reg.pc);
              state_next.push = 1'b1;
              state_next.pc = {upper_pc_latch[6:3], op_literal};
              state_next.phase = ST_SECOND;
            end
            exec_pkg::OP_CALL_VIA_ACC: begin
              state_next.ret_addr = pc_inc(state_reg.pc);
              state_next.push = 1'b1;
              state_next.pc = {upper_pc_latch, state_reg.acc};
              state_next.phase = ST_SECOND;
            end
            exec_pkg::OP_BIT_SET: begin
              file_we = 1'b1;
              file_wdata = file_rd | (8'h01 << op_bit);
            end
            exec_pkg::OP_INVERT_FILE, exec_pkg::OP_DECREMENT_FILE: begin
              // modulo-256 wrap, no carry kept
              res = (op_code == exec_pkg::OP_INVERT_FILE) ? ~file_rd
                                                          : file_rd - 8'h01;
              state_next.zero = is_zero(res);
              if (op_dest) begin
                file_we = 1'b1;
                file_wdata = res;
              end else begin
                state_next.acc = res;
              end
            end
            exec_pkg::OP_ZERO_FILE: begin
              file_we = 1'b1;
              file_wdata = exec_pkg::FILE_RESET;
              state_next.zero = 1'b1;
            end
            exec_pkg::OP_ZERO_ACC: begin
              state_next.acc = exec_pkg::ACC_RESET;
              state_next.zero = 1'b1;
            end
            default: begin
              state_next.pc = state_reg.pc;
            end
          endcase
        end
      end
      default: state_next.phase = ST_IDLE;
    endcase
  end

  // state register; file cleared on reset so reads are never unknown
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '{phase: ST_IDLE, pc: exec_pkg::PC_RESET, acc: exec_pkg::ACC_RESET,
                     zero: exec_pkg::ZERO_RESET, ret_addr: exec_pkg::PC_RESET, push: 1'b0};
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= exec_pkg::FILE_RESET;
      end
    end else begin
      state_reg <= state_next;
      if (file_we) begin
        file_mem[op_file_addr] <= file_wdata;
      end
    end
  end

  assign op_ready = (state_reg.phase == ST_IDLE);
  assign pc = state_reg.pc;
  assign acc = state_reg.acc;
  assign zero_flag = state_reg.zero;
  assign stack_top_entry = state_reg.ret_addr;
  assign stack_push = state_reg.push;

  // checks
  logic op_fire;
  assign op_fire = op_valid && op_ready;

  a_branch_target: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_BRANCH_REL_ACC
    |=> pc == $past(pc) + 15'h0001 + {7'h00, $past(acc)})
    else $error("branch target wrong");
  // the held request in the dead cycle must not move pc again
  a_branch_timing: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_BRANCH_REL_ACC
    |=> !op_ready && $stable(zero_flag) && $stable(acc) ##1 op_ready && $stable(pc))
    else $error("branch timing or flags wrong");
  a_call_abs_pc: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_CALL_ABS
    |=> pc == {$past(upper_pc_latch[6:3]), $past(op_literal)} && stack_push)
    else $error("absolute call target wrong");
  a_call_abs_ret: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_CALL_ABS |=> stack_top_entry == $past(pc) + 15'h0001)
    else $error("absolute call return address wrong");
  a_call_abs_flags: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_CALL_ABS
    |=> !op_ready ##1 op_ready && $stable(zero_flag))
    else $error("absolute call timing or flags wrong");
  a_call_acc_pc: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_CALL_VIA_ACC
    |=> pc == {$past(upper_pc_latch), $past(acc)} && stack_top_entry == $past(pc) + 15'h0001)
    else $error("call via acc wrong");
  a_call_acc_time: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_CALL_VIA_ACC |=> !op_ready && $stable(zero_flag))
    else $error("call via acc not two cycles");
  // the stored byte is judged, not the write strobe, so a lost write shows
  a_bit_set: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_BIT_SET
    |=> file_mem[$past(op_file_addr)][$past(op_bit)] && $stable(zero_flag) && $stable(acc)
        && (file_mem[$past(op_file_addr)] | (8'h01 << $past(op_bit)))
           == ($past(file_rd) | (8'h01 << $past(op_bit))))
    else $error("bit set failed");
  a_invert_acc: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_INVERT_FILE && !op_dest
    |=> acc == ~$past(file_rd) && zero_flag == ($past(file_rd) == 8'hff))
    else $error("invert into acc wrong");
  a_invert_file: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_INVERT_FILE && op_dest
    |=> file_mem[$past(op_file_addr)] == ~$past(file_rd) && $stable(acc)
        && zero_flag == ($past(file_rd) == 8'hff))
    else $error("invert into file wrong");
  a_zero_file: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_ZERO_FILE
    |=> zero_flag && op_ready && file_mem[$past(op_file_addr)] == 8'h00)
    else $error("clear file flag wrong");
  a_decrement_acc: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_DECREMENT_FILE && !op_dest
    |=> acc == $past(file_rd) - 8'h01 && zero_flag == ($past(file_rd) == 8'h01))
    else $error("decrement into acc wrong");
  a_decrement_file: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_DECREMENT_FILE && op_dest
    |=> file_mem[$past(op_file_addr)] == $past(file_rd) - 8'h01 && $stable(acc)
        && zero_flag == ($past(file_rd) == 8'h01))
    else $error("decrement into file wrong");
  a_zero_acc: assert property (@(posedge clk) disable iff (reset)
    op_fire && op_code == exec_pkg::OP_ZERO_ACC |=> acc == 8'h00 && zero_flag && op_ready)
    else $error("clear acc wrong");

  c_branch: cover property (@(posedge clk) op_fire && op_code == exec_pkg::OP_BRANCH_REL_ACC);
  c_call_abs: cover property (@(posedge clk) op_fire && op_code == exec_pkg::OP_CALL_ABS);
  c_dec_wrap: cover property (@(posedge clk)
    op_fire && op_code == exec_pkg::OP_DECREMENT_FILE && file_rd == 8'h00);
  c_invert_file: cover property (@(posedge clk)
    op_fire && op_code == exec_pkg::OP_INVERT_FILE && op_dest);
endmodule

// [core_branch_call_clear_ops_tb.sv]
/*
  self-checking bench for the partial instruction executor.
  assumes exec_pkg is compiled first; the bench drives all ports itself.
*/
`timescale 1ns/1ps
module core_branch_call_clear_ops_tb;
  logic clk, reset, op_valid, op_dest, op_ready, zero_flag, stack_push;
  logic [2:0] op_code, op_bit;
  logic [10:0] op_literal;
  logic [6:0] op_file_addr, upper_pc_latch;
  logic [14:0] pc, stack_top_entry;
  logic [7:0] acc;
  int num_errors = 0;
  int n_compared = 0;

  core_branch_call_clear_ops u_dut (.clk(clk), .reset(reset), .op_valid(op_valid),
    .op_code(op_code), .op_literal(op_literal), .op_file_addr(op_file_addr),
    .op_bit(op_bit), .op_dest(op_dest), .upper_pc_latch(upper_pc_latch),
    .op_ready(op_ready), .pc(pc), .acc(acc), .zero_flag(zero_flag),
    .stack_top_entry(stack_top_entry), .stack_push(stack_push));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one instruction; valid stays high so single ops can follow back to back
  // and the held request during a stall must be refused
  task automatic run(input logic [2:0] c, input logic [10:0] l, input logic [6:0] a,
                     input logic [2:0] b, input logic d, input logic [6:0] h);
    logic lng;
    lng = (c == 3'h0 || c == 3'h1 || c == 3'h3);
    op_code = c;
    op_literal = l;
    op_file_addr = a;
    op_bit = b;
    op_dest = d;
    upper_pc_latch = h;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    chk(stack_push, c == 3'h1 || c == 3'h3);
    chk(op_ready, !lng);
    if (lng) begin
      @(posedge clk);
      #1;
      chk(op_ready, 1'b1);
      chk(stack_push, 1'b0);
    end
  endtask

  // ten cycles of reset; every output must then show its reset value
  task automatic t_reset();
    reset = 1'b1;
    op_valid = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    chk(pc, 15'h0000);
    chk(acc, 8'h00);
    chk(zero_flag, 1'b0);
    chk(stack_top_entry, 15'h0000);
    chk(op_ready, 1'b1);
    chk(stack_push, 1'b0);
  endtask

  // file ops: leaves acc 10h, zero set, pc 4
  task automatic t_file();
    run(exec_pkg::OP_BIT_SET, 11'h000, 7'h05, 3'h4, 1'b1, 7'h00);
    chk(zero_flag, 1'b0);
    run(exec_pkg::OP_INVERT_FILE, 11'h000, 7'h05, 3'h0, 1'b1, 7'h00);
    chk(acc, 8'h00);
    run(exec_pkg::OP_INVERT_FILE, 11'h000, 7'h05, 3'h0, 1'b0, 7'h00);
    chk(acc, 8'h10);
    chk(zero_flag, 1'b0);
    run(exec_pkg::OP_ZERO_FILE, 11'h000, 7'h07, 3'h0, 1'b0, 7'h00);
    chk(zero_flag, 1'b1);
    chk(pc, 15'h0004);
  endtask

  // branch and calls with zero set, so a flag disturbance shows
  task automatic t_branch();
    run(exec_pkg::OP_BRANCH_REL_ACC, 11'h000, 7'h00, 3'h0, 1'b0, 7'h00);
    chk(pc, 15'h0015);
    run(exec_pkg::OP_CALL_ABS, 11'h7ff, 7'h00, 3'h0, 1'b0, 7'h58);
    chk(pc, 15'h5fff);
    chk(stack_top_entry, 15'h0016);
    run(exec_pkg::OP_CALL_VIA_ACC, 11'h000, 7'h00, 3'h0, 1'b0, 7'h05);
    chk(pc, 15'h0510);
    chk(stack_top_entry, 15'h6000);
    chk(zero_flag, 1'b1);
  endtask

  // acc and flag ops; checks after a change catch a stuck value, the rest check that acc or zero holds
  task automatic t_acc();
    run(exec_pkg::OP_DECREMENT_FILE, 11'h000, 7'h07, 3'h0, 1'b0, 7'h00);
    chk(acc, 8'hff);
    chk(zero_flag, 1'b0);
    run(exec_pkg::OP_DECREMENT_FILE, 11'h000, 7'h07, 3'h0, 1'b1, 7'h00);
    chk(acc, 8'hff);
    run(exec_pkg::OP_BIT_SET, 11'h000, 7'h09, 3'h0, 1'b1, 7'h00);
    run(exec_pkg::OP_DECREMENT_FILE, 11'h000, 7'h09, 3'h0, 1'b0, 7'h00);
    chk(acc, 8'h00);
    chk(zero_flag, 1'b1);
    run(exec_pkg::OP_INVERT_FILE, 11'h000, 7'h07, 3'h0, 1'b0, 7'h00);
    chk(acc, 8'h00);
    chk(zero_flag, 1'b1);
    run(exec_pkg::OP_BIT_SET, 11'h000, 7'h09, 3'h7, 1'b1, 7'h00);
    chk(zero_flag, 1'b1);
    run(exec_pkg::OP_ZERO_FILE, 11'h000, 7'h05, 3'h0, 1'b0, 7'h00);
    run(exec_pkg::OP_INVERT_FILE, 11'h000, 7'h05, 3'h0, 1'b0, 7'h00);
    chk(acc, 8'hff);
    chk(zero_flag, 1'b0);
    run(exec_pkg::OP_INVERT_FILE, 11'h000, 7'h09, 3'h0, 1'b0, 7'h00);
    chk(acc, 8'h7e);
    run(exec_pkg::OP_ZERO_ACC, 11'h000, 7'h00, 3'h0, 1'b0, 7'h00);
    chk(acc, 8'h00);
    chk(zero_flag, 1'b1);
    chk(pc, 15'h051a);
  endtask

  // hang guard: a stuck run counts as a mismatch
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    {op_dest, op_code, op_bit} = 7'h00;
    {op_literal, op_file_addr, upper_pc_latch} = 25'h0;
    t_reset();
    t_file();
    t_branch();
    t_acc();
    // second reset in mid-run: file byte 09h must read back as 00h again
    t_reset();
    run(exec_pkg::OP_INVERT_FILE, 11'h000, 7'h09, 3'h0, 1'b0, 7'h00);
    chk(acc, 8'hff);
    chk(pc, 15'h0001);
    op_valid = 1'b0;
    results();
  end
endmodule

// [exec_pkg.sv]
/*
  shared constants for the partial instruction executor: opcode encoding,
  widths, reset values and cycle counts.
  assumes one clock domain and a synchronous active-high reset.
*/
package exec_pkg;
  localparam int PC_W = 15;
  localparam int DATA_W = 8;
  localparam int FILE_ADDR_W = 7;
  localparam int LIT_W = 11;
  localparam int LATCH_W = 7;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam int LONG_CYCLES = 2;
  localparam int SHORT_CYCLES = 1;

  typedef enum logic [2:0] {
    OP_BRANCH_REL_ACC = 3'h0,
    OP_CALL_ABS = 3'h1,
    OP_BIT_SET = 3'h2,
    OP_CALL_VIA_ACC = 3'h3,
    OP_INVERT_FILE = 3'h4,
    OP_ZERO_FILE = 3'h5,
    OP_DECREMENT_FILE = 3'h6,
    OP_ZERO_ACC = 3'h7
  } op_t;
endpackage
